//--- core/prb_map.svh
`ifndef PRB_MAP_SVH
`define PRB_MAP_SVH

// Command-address field positions
`define PRB_CA_WIDTH 48
`define PRB_CA_DIR 47
`define PRB_CA_SPACE 46
`define PRB_CA_LINEAR 45
`define PRB_CA_UP_HI 44
`define PRB_CA_UP_LO 16
`define PRB_CA_LO_HI 2
`define PRB_CA_LAST_BYTE 3'h5

// Wrap masks in words for the burst length selector
`define PRB_WRAP_16B 6'h07
`define PRB_WRAP_32B 6'h0F
`define PRB_WRAP_64B 6'h1F
`define PRB_WRAP_128B 6'h3F

// Reset values and the register write byte enable
`define PRB_PIN_IDLE 1'b1
`define PRB_LAT_RST 6'h00
`define PRB_FULL_WORD 2'h3

`endif

//--- core/prb_pkg.sv
`default_nettype none

package prb_pkg;

	typedef enum logic [5:0] {
		PRB_ST_IDLE = 6'b000001,
		PRB_ST_CMD = 6'b000010,
		PRB_ST_LAT = 6'b000100,
		PRB_ST_RDAT = 6'b001000,
		PRB_ST_WDAT = 6'b010000,
		PRB_ST_SKIP = 6'b100000
	} prb_state_e;

	typedef logic [1:0] prb_blen_t;

endpackage

`default_nettype wire

//--- core/prb_ag_if.sv
`default_nettype none

interface prb_ag_if #(
	parameter int AW = 23
);
	import prb_pkg::*;

	logic load;
	logic step;
	logic [AW-1:0] start_addr;
	logic wrapped;
	logic hybrid;
	prb_blen_t len_sel;
	logic [AW-1:0] addr;

	modport ctrl (
		output load,
		output step,
		output start_addr,
		output wrapped,
		output hybrid,
		output len_sel,
		input addr
	);

	modport gen (
		input load,
		input step,
		input start_addr,
		input wrapped,
		input hybrid,
		input len_sel,
		output addr
	);

endinterface

`default_nettype wire

//--- core/prb_addr_gen.sv
`default_nettype none
`include "prb_map.svh"

module prb_addr_gen
	import prb_pkg::*;
#(
	parameter int AW = 23
) (
	input wire logic clock,
	input wire logic nrst,
	prb_ag_if.gen ag
);

	typedef struct packed {
		logic [AW-1:0] addr;
		logic wrap;
		logic hyb;
		logic [5:0] cnt;
		logic [5:0] mask;
	} prb_ag_s;

	prb_ag_s r;
	prb_ag_s n;
	logic [5:0] m;
	logic [AW-1:0] m_ext;

	always_comb begin
		case (ag.len_sel)
			2'h0: m = `PRB_WRAP_16B;
			2'h1: m = `PRB_WRAP_32B;
			2'h2: m = `PRB_WRAP_64B;
			default: m = `PRB_WRAP_128B;
		endcase
	end

	assign m_ext = {{(AW-6){1'b0}}, r.mask};

	always_comb begin
		n = r;
		if (ag.load) begin
			n.addr = ag.start_addr;
			n.wrap = ag.wrapped;
			n.hyb = ag.hybrid;
			n.cnt = 6'h00;
			n.mask = m;
		end else if (ag.step) begin
			if (!r.wrap) begin
				// Linear runs off the top back to zero
				n.addr = r.addr + {{(AW-1){1'b0}}, 1'b1};
			end else if (r.hyb && r.cnt == r.mask) begin
				// One full wrap done: go linear from next boundary
				n.addr = (r.addr | m_ext) + {{(AW-1){1'b0}}, 1'b1};
				n.wrap = 1'b0;
			end else begin
				n.addr = (r.addr & ~m_ext) |
					((r.addr + {{(AW-1){1'b0}}, 1'b1}) & m_ext);
				n.cnt = r.cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign ag.addr = r.addr;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	a_wrap_stays: assert property (
		ag.step && !ag.load && r.wrap && !r.hyb |=>
		(r.addr & ~m_ext) == ($past(r.addr) & ~m_ext))
		else $error("wrapped burst left its window");

	a_linear_next: assert property (
		ag.step && !ag.load && !r.wrap |=>
		r.addr == $past(r.addr) + {{(AW-1){1'b0}}, 1'b1})
		else $error("linear burst did not advance by one");

endmodule

`default_nettype wire

//--- core/prb_core.sv
// Notes on behaviour
// - Command bit 47 high means read, low means write.
// - Command bit 46 low selects array, high selects register space.
// - Command bit 45 picks wrapped or linear burst per transaction.
// - Access starts only after all six bytes; last word picks word in row.
// - Fixed latency only; strobe high during command so latency is doubled.
// - Strobe high during command doubles the latency count before read data.
// - After latency, strobe toggles with read data, edge aligned, whole read.
// - Read data continues while clock toggles; strobe may idle low between words.
// - Wrapped reads wrap in burst length; linear reads run on sequentially.
// - Write byte A taken on clock rise, byte B on clock fall.
// - On writes, device drives strobe from select low through command, then releases it.
// - Write bytes with strobe high are masked, strobe low are stored.
// - No latency signalling during write data; host owns the strobe.
// - Hybrid wrapped write wraps once then continues linear from next boundary.
// - Linear write past the last address continues at address zero.
// - Command arrives in first three clocks: direction, space, burst type.
// - Register write has zero latency, ignores strobe, writes both bytes.
// - Host never drives strobe in zero latency writes; device floats it.
// - Latency count comes from config register zero latency field.
`default_nettype none
`include "prb_map.svh"

module prb_core
	import prb_pkg::*;
#(
	parameter int AW = 23
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic ck,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe_n,
	input wire logic strobe_mask_in,
	output logic strobe_mask_out,
	output logic strobe_mask_oe_n,
	input wire logic [3:0] config_reg_zero_latency,
	input wire logic [1:0] burst_len_sel,
	input wire logic hybrid_en,
	output logic acc_rd,
	output logic acc_wr,
	output logic acc_reg,
	output logic [AW-1:0] acc_addr,
	output logic [15:0] acc_wdata,
	output logic [1:0] acc_be,
	input wire logic [15:0] acc_rdata
);

	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic ck_m;
		logic ck_s;
		logic ck_q;
		logic [7:0] dq_m;
		logic [7:0] dq_s;
		logic sm_m;
		logic sm_s;
		prb_state_e st;
		logic [2:0] bcnt;
		logic [`PRB_CA_WIDTH-1:0] ca;
		logic [5:0] lat;
		logic rd;
		logic reg_sp;
		logic half;
		logic [7:0] wbyte;
		logic wmask_a;
		logic [15:0] rword;
		logic fetch;
		logic ld;
		logic stp;
		logic [7:0] dq_o;
		logic dq_oe_n;
		logic sm_o;
		logic sm_oe_n;
		logic acc_rd;
		logic acc_wr;
		logic acc_reg;
		logic [AW-1:0] acc_addr;
		logic [15:0] acc_wdata;
		logic [1:0] acc_be;
	} prb_core_s;

	prb_core_s r;
	prb_core_s n;

	prb_ag_if #(.AW(AW)) ag ();

	prb_addr_gen #(
		.AW(AW)
	) u_addr_gen (
		.clock(clock),
		.nrst(nrst),
		.ag(ag)
	);

	logic rise;
	logic fall;
	logic any_edge;
	logic ca_done;
	logic lat_end;
	logic drise;
	logic dfall;
	logic [5:0] lat_tgt;
	logic [31:0] ca_word;
	logic [`PRB_CA_WIDTH-1:0] ca_new;

	// Edges of the sampled link clock
	assign rise = r.ck_s && !r.ck_q;
	assign fall = !r.ck_s && r.ck_q;
	assign any_edge = rise || fall;

	// Fixed latency: the count is always applied twice
	assign lat_tgt = {1'b0, config_reg_zero_latency, 1'b0};
	assign lat_end = (r.st == PRB_ST_LAT) && (r.lat == lat_tgt);

	assign ca_new = {r.ca[`PRB_CA_WIDTH-9:0], r.dq_s};
	assign ca_done = (r.st == PRB_ST_CMD) && any_edge &&
		(r.bcnt == `PRB_CA_LAST_BYTE);

	// Word address: upper column and row, then word within half-page
	assign ca_word = {r.ca[`PRB_CA_UP_HI:`PRB_CA_UP_LO],
		r.ca[`PRB_CA_LO_HI:0]};

	assign drise = rise && (lat_end || r.st == PRB_ST_RDAT ||
		r.st == PRB_ST_WDAT);
	assign dfall = fall && r.half &&
		(r.st == PRB_ST_RDAT || r.st == PRB_ST_WDAT);

	assign ag.load = r.ld;
	assign ag.step = r.stp;
	assign ag.start_addr = ca_word[AW-1:0];
	assign ag.wrapped = !r.ca[`PRB_CA_LINEAR];
	assign ag.hybrid = hybrid_en && !r.rd;
	assign ag.len_sel = burst_len_sel;

	always_comb begin
		n = r;
		n.cs_m = cs_n;
		n.cs_s = r.cs_m;
		n.ck_m = ck;
		n.ck_s = r.ck_m;
		n.ck_q = r.ck_s;
		n.dq_m = dq_in;
		n.dq_s = r.dq_m;
		n.sm_m = strobe_mask_in;
		n.sm_s = r.sm_m;
		n.acc_rd = 1'b0;
		n.acc_wr = 1'b0;
		n.ld = 1'b0;
		n.stp = 1'b0;

		// Address settles one cycle after load or step, then fetch
		n.fetch = r.rd && (r.ld || r.stp);
		if (r.acc_rd) begin
			n.rword = acc_rdata;
		end
		if (r.fetch) begin
			n.acc_rd = 1'b1;
			n.acc_addr = ag.addr;
			n.acc_reg = r.reg_sp;
		end

		case (r.st)
			PRB_ST_IDLE: begin
				if (!r.cs_s) begin
					// Strobe up before any command byte is seen
					n.st = PRB_ST_CMD;
					n.bcnt = 3'h0;
					n.sm_o = 1'b1;
					n.sm_oe_n = 1'b0;
					n.half = 1'b0;
				end
			end
			PRB_ST_CMD: begin
				if (any_edge) begin
					n.ca = ca_new;
					n.bcnt = r.bcnt + 3'h1;
				end
				if (ca_done) begin
					n.rd = ca_new[`PRB_CA_DIR];
					n.reg_sp = ca_new[`PRB_CA_SPACE];
					n.ld = 1'b1;
					n.lat = `PRB_LAT_RST;
					if (ca_new[`PRB_CA_DIR]) begin
						// Read: keep strobe, park it low during latency
						n.sm_o = 1'b0;
						n.st = PRB_ST_LAT;
					end else begin
						// Write: hand the strobe to the host
						n.sm_oe_n = 1'b1;
						n.sm_o = 1'b0;
						if (ca_new[`PRB_CA_SPACE]) begin
							n.st = PRB_ST_WDAT;
						end else begin
							n.st = PRB_ST_LAT;
						end
					end
				end
			end
			PRB_ST_LAT: begin
				if (rise && !lat_end) begin
					n.lat = r.lat + 6'h01;
				end
				if (drise) begin
					n.st = r.rd ? PRB_ST_RDAT : PRB_ST_WDAT;
				end
			end
			PRB_ST_RDAT: begin
			end
			PRB_ST_WDAT: begin
			end
			PRB_ST_SKIP: begin
			end
			default: begin
				n.st = PRB_ST_IDLE;
			end
		endcase

		if (drise) begin
			n.half = 1'b1;
			if (r.rd) begin
				// Byte A goes out with the strobe rising
				n.dq_o = r.rword[15:8];
				n.dq_oe_n = 1'b0;
				n.sm_o = 1'b1;
			end else begin
				n.wbyte = r.dq_s;
				n.wmask_a = r.sm_s;
			end
		end

		if (dfall) begin
			n.half = 1'b0;
			if (r.rd) begin
				n.dq_o = r.rword[7:0];
				n.sm_o = 1'b0;
				// Register reads repeat the same word
				n.stp = !r.reg_sp;
			end else begin
				n.acc_wr = 1'b1;
				n.acc_addr = ag.addr;
				n.acc_reg = r.reg_sp;
				n.acc_wdata = {r.wbyte, r.dq_s};
				if (r.reg_sp) begin
					n.acc_be = `PRB_FULL_WORD;
					n.st = PRB_ST_SKIP;
				end else begin
					n.acc_be = {!r.wmask_a, !r.sm_s};
					n.stp = 1'b1;
				end
			end
		end

		// Select high ends everything and floats the pins
		if (r.cs_s && r.st != PRB_ST_IDLE) begin
			n.st = PRB_ST_IDLE;
			n.dq_oe_n = `PRB_PIN_IDLE;
			n.sm_oe_n = `PRB_PIN_IDLE;
			n.sm_o = 1'b0;
			n.half = 1'b0;
			n.fetch = 1'b0;
			n.stp = 1'b0;
			n.ld = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.cs_m <= `PRB_PIN_IDLE;
			r.cs_s <= `PRB_PIN_IDLE;
			r.st <= PRB_ST_IDLE;
			r.dq_oe_n <= `PRB_PIN_IDLE;
			r.sm_oe_n <= `PRB_PIN_IDLE;
		end else begin
			r <= n;
		end
	end

	assign dq_out = r.dq_o;
	assign dq_oe_n = r.dq_oe_n;
	assign strobe_mask_out = r.sm_o;
	assign strobe_mask_oe_n = r.sm_oe_n;
	assign acc_rd = r.acc_rd;
	assign acc_wr = r.acc_wr;
	assign acc_reg = r.acc_reg;
	assign acc_addr = r.acc_addr;
	assign acc_wdata = r.acc_wdata;
	assign acc_be = r.acc_be;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_ca_done;
		ca_done && !r.cs_s;
	endsequence

	sequence s_first_data;
		r.st == PRB_ST_LAT ##1 r.st == PRB_ST_RDAT;
	endsequence

	a_ca_strobe_hi: assert property (
		r.st == PRB_ST_CMD |-> !r.sm_oe_n && r.sm_o)
		else $error("strobe not driven high during command");

	a_dir_decode: assert property (
		s_ca_done |=> r.rd == r.ca[`PRB_CA_DIR])
		else $error("direction not taken from bit 47");

	a_space_decode: assert property (
		s_ca_done |=> r.reg_sp == r.ca[`PRB_CA_SPACE])
		else $error("space not taken from bit 46");

	a_burst_load: assert property (
		s_ca_done |=> r.ld ##1
		(u_addr_gen.r.wrap == !r.ca[`PRB_CA_LINEAR]))
		else $error("burst type not loaded");

	a_ca_count: assert property (
		r.st == PRB_ST_CMD && !ca_done |=>
		r.st == PRB_ST_CMD || r.st == PRB_ST_IDLE)
		else $error("command phase left before six bytes");

	a_cs_release: assert property (
		r.cs_s && r.st != PRB_ST_IDLE |=>
		r.st == PRB_ST_IDLE && r.dq_oe_n && r.sm_oe_n)
		else $error("pins not floated after select rise");

	a_lat_wait: assert property (
		s_first_data |-> $past(r.lat) == lat_tgt)
		else $error("read data before doubled latency");

	a_read_drive: assert property (
		r.st == PRB_ST_RDAT |-> !r.sm_oe_n && !r.dq_oe_n)
		else $error("read pins not driven");

	a_edge_align: assert property (
		drise && r.rd && !r.cs_s |=>
		r.sm_o && r.dq_o == $past(r.rword[15:8]))
		else $error("byte A not aligned with strobe rise");

	a_wdat_float: assert property (
		r.st == PRB_ST_WDAT || r.st == PRB_ST_SKIP |-> r.sm_oe_n)
		else $error("device drove strobe in write data");

	a_reg_full: assert property (
		r.acc_wr && r.acc_reg |-> r.acc_be == `PRB_FULL_WORD)
		else $error("register write was masked");

	a_mem_mask: assert property (
		r.acc_wr && !r.acc_reg |->
		r.acc_be == {!r.wmask_a, !$past(r.sm_s)})
		else $error("write mask not taken from strobe");

endmodule

`default_nettype wire

//--- testbench/prb_host.sv
`default_nettype none

module prb_host (
	input wire logic clock,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe_n,
	input wire logic strobe_mask_out,
	input wire logic strobe_mask_oe_n,
	output logic cs_n,
	output logic ck,
	output logic [7:0] dq_in,
	output logic strobe_mask_in,
	output logic ca_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] hdq, dql;
	logic hdoe, hroe, hrw, rwl;
	// Released lines toggle instead of holding their last level
	assign dq_in = !dq_oe_n ? dq_out : hdoe ? hdq : ~dql;
	assign strobe_mask_in = !strobe_mask_oe_n ? strobe_mask_out :
		hroe ? hrw : ~rwl;
	always @(posedge clock) begin
		dql <= dq_in;
		rwl <= strobe_mask_in;
	end
	initial begin
		cs_n = 1'b1;
		ck = 1'b0;
		hdoe = 1'b0;
		hroe = 1'b0;
		hrw = 1'b0;
		hdq = 8'h00;
		dql = 8'h00;
		rwl = 1'b0;
		ca_ok = 1'b0;
	end
	// Data stands two cycles either side of each clock edge
	task automatic half(input logic [7:0] d, input logic m);
		hdq = d;
		hrw = m;
		repeat (2) @(negedge clock);
		ck = ~ck;
		repeat (2) @(negedge clock);
	endtask
	task automatic start(input logic [47:0] ca, input int k);
		cs_n = 1'b0;
		hdoe = 1'b1;
		ca_ok = 1'b1;
		repeat (8) @(negedge clock);
		for (int i = 0; i < k; i++) begin
			ca_ok &= strobe_mask_in;
			half(ca[47 - 8 * i -: 8], 1'b0);
		end
	endtask
	task automatic xfer(input int lat, input int n, input logic wr,
		input logic msk_en, input logic [31:0] msk);
		logic [15:0] w;
		hdoe = wr;
		hroe = msk_en;
		for (int j = 0; j < 2 * (lat + n); j++) begin
			w = 16'hA050 + 16'(j / 2 - lat) * 16'h0101;
			half(j[0] ? w[7:0] : w[15:8], j >= 2 * lat && msk[j - 2 * lat]);
		end
	endtask
	// Select rises with the clock low; long idle covers recovery
	task automatic stop();
		hdoe = 1'b0;
		hroe = 1'b0;
		repeat (6) @(negedge clock);
		cs_n = 1'b1;
		repeat (8) @(negedge clock);
	endtask
endmodule

`default_nettype wire

//--- testbench/prb_core_tb_top.sv
`default_nettype none

module prb_core_tb_top;
	import prb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic dir, sp, lin, hyb;
		logic [22:0] a;
		logic [3:0] lat;
		logic [1:0] len;
		int n;
		logic [31:0] msk;
	} prb_row_s;
	// Last row is a register write with the linear bit set
	prb_row_s rows[8] = '{
		'{1, 0, 1, 0, 23'h1FE, 1, 0, 4, 0},
		'{1, 0, 0, 0, 23'h5E, 2, 2, 4, 0},
		'{1, 0, 0, 0, 23'h2E, 0, 1, 3, 0},
		'{1, 1, 0, 0, 23'h1, 3, 0, 2, 0},
		'{0, 0, 1, 0, 23'h7FFFFF, 1, 0, 2, 32'h6},
		'{0, 0, 0, 0, 23'h3E, 4, 3, 3, 0},
		'{0, 0, 0, 1, 23'h5, 1, 0, 10, 32'h1},
		'{0, 1, 1, 0, 23'h0, 2, 0, 2, 0}};
	logic clock = 1'b0;
	logic nrst, cs_n, ck, strobe_mask_in, ca_ok, hyb_in, ps;
	logic dq_oe_n, strobe_mask_out, strobe_mask_oe_n, acc_rd, acc_wr, acc_reg;
	logic [7:0] dq_in, dq_out;
	logic [3:0] lat_in;
	logic [1:0] len_in, acc_be;
	logic [22:0] acc_addr;
	logic [15:0] acc_wdata, acc_rdata;
	logic [7:0] rq[$];
	logic [42:0] aq[$];
	int fail_count = 0;
	int n_compared = 0;

	always #10 clock = ~clock;
	assign acc_rdata = {acc_addr[7:0], ~acc_addr[7:0]};

	prb_core u_prb_core (.clock(clock), .nrst(nrst), .cs_n(cs_n), .ck(ck),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.strobe_mask_in(strobe_mask_in), .strobe_mask_out(strobe_mask_out),
		.strobe_mask_oe_n(strobe_mask_oe_n), .config_reg_zero_latency(lat_in),
		.burst_len_sel(len_in), .hybrid_en(hyb_in), .acc_rd(acc_rd),
		.acc_wr(acc_wr), .acc_reg(acc_reg), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .acc_be(acc_be), .acc_rdata(acc_rdata));
	prb_host u_prb_host (.clock(clock), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.strobe_mask_out(strobe_mask_out), .strobe_mask_oe_n(strobe_mask_oe_n),
		.cs_n(cs_n), .ck(ck), .dq_in(dq_in), .strobe_mask_in(strobe_mask_in),
		.ca_ok(ca_ok));

	always @(posedge clock) begin
		ps <= strobe_mask_out;
		if (!dq_oe_n && !strobe_mask_oe_n && strobe_mask_out !== ps)
			rq.push_back(dq_out);
		if (acc_rd || acc_wr)
			aq.push_back({acc_wr, acc_reg, acc_addr, acc_wdata, acc_be});
	end

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	function automatic logic [47:0] mk(prb_row_s r);
		return {r.dir, r.sp, r.lin, 9'h0, r.a[22:3], 13'h0, r.a[2:0]};
	endfunction
	function automatic logic [22:0] ea(prb_row_s r, int i);
		logic [22:0] m;
		m = (23'h8 << r.len) - 23'h1;
		if (r.sp)
			return r.a;
		if (r.lin)
			return r.a + 23'(i);
		if (r.hyb && !r.dir && i > int'(m))
			return (r.a & ~m) + 23'(i);
		return (r.a & ~m) | ((r.a + 23'(i)) & m);
	endfunction
	task automatic do_row(prb_row_s r);
		logic [42:0] e;
		logic [22:0] x;
		int k;
		k = r.sp ? 1 : r.n;
		lat_in = r.lat;
		len_in = r.len;
		hyb_in = r.hyb;
		rq.delete();
		aq.delete();
		u_prb_host.start(mk(r), 6);
		u_prb_host.xfer((r.sp && !r.dir) ? 0 : 2 * r.lat, r.n, !r.dir,
			!r.dir && !r.sp, r.msk);
		u_prb_host.stop();
		chk(ca_ok, 1);
		chk({dq_oe_n, strobe_mask_oe_n}, 2'b11);
		if (r.dir) begin
			chk(rq.size(), 2 * r.n);
			// Register reads fetch once; array reads prefetch one past the end
			chk(aq.size(), r.sp ? 1 : r.n + 1);
			for (int i = 0; i < r.n; i++) begin
				x = ea(r, i);
				if (i < k)
					chk(aq[i][42:18], {1'b0, r.sp, x});
				chk({rq[2 * i], rq[2 * i + 1]}, {x[7:0], ~x[7:0]});
			end
		end else begin
			chk(aq.size(), k);
			for (int i = 0; i < k; i++) begin
				x = ea(r, i);
				e = {1'b1, r.sp, x, 16'hA050 + 16'(i) * 16'h0101,
					~r.msk[2 * i], ~r.msk[2 * i + 1]};
				chk(aq[i], e);
			end
		end
	endtask

	initial begin
		nrst = 1'b0;
		lat_in = 4'h0;
		len_in = 2'h0;
		hyb_in = 1'b0;
		repeat (8) @(negedge clock);
		chk({dq_oe_n, strobe_mask_oe_n, acc_rd, acc_wr}, 4'hC);
		nrst = 1'b1;
		repeat (2) @(negedge clock);
		foreach (rows[i])
			do_row(rows[i]);
		// Select rises after four of six command bytes, clock low
		aq.delete();
		u_prb_host.start(mk(rows[0]), 4);
		u_prb_host.stop();
		chk(aq.size(), 0);
		do_row(rows[3]);
		// Reset in the middle of a transfer
		u_prb_host.start(mk(rows[0]), 6);
		nrst = 1'b0;
		@(negedge clock);
		chk({dq_oe_n, strobe_mask_oe_n}, 2'b11);
		nrst = 1'b1;
		u_prb_host.stop();
		do_row(rows[1]);
		wrap_up();
	end
	initial begin
		repeat (100000) @(posedge clock);
		fail_count++;
		wrap_up();
	end
endmodule

`default_nettype wire
